//--- spf_event_filter.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
module spf_event_filter (
  input wire logic clk, // Controller clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic cmdValid, // Command received pulse
  input wire logic cmdWrite, // Command is a write
  input wire logic cmdRegion, // Command targets controller registers
  input wire logic [7:0] cmdRequesterId, // Command master identifier
  input wire logic [7:0] cmdLen, // Transfer size in bytes
  input wire logic actIssue, // ACTIVATE issued pulse
  input wire logic [7:0] actRequesterId, // Master behind the ACTIVATE
  input wire logic fifoFull, // Command FIFO full
  input wire logic fifoNotEmpty, // Command FIFO holds a command
  input wire logic xferDone, // Transfer completed pulse
  input wire logic oldestRegion, // Oldest command targets registers
  input wire logic [7:0] oldestRequesterId, // Oldest command master
  output logic prioRaise // Oldest command priority raise pulse
);

  logic [31:0] count1_reg;
  logic [31:0] count2_reg;
  logic [31:0] config_reg;
  logic [31:0] select_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] xferCount_reg;
  logic [7:0] xferCount_next;
  logic [8:0] chunks;
  logic [31:0] inc1;
  logic [31:0] inc2;
  logic apbAccess;
  logic apbWrite;
  logic thrHit;

  // Region filter match
  function automatic logic regionOk(input logic en, input logic [3:0] sel, input logic isReg);
    regionOk = !en || (sel == spf_pkg::RSEL_SDRAM && !isReg) || (sel == spf_pkg::RSEL_REGS && isReg);
  endfunction

  // Increment for one counter from its code and filters
  function automatic logic [31:0] countInc(input logic [3:0] code, input logic rEn, input logic iEn,
                                           input logic [3:0] rSel, input logic [7:0] rId);
    logic cmdOk;
    cmdOk = regionOk(rEn, rSel, cmdRegion) && (!iEn || cmdRequesterId == rId);
    countInc = 32'h0000_0000;
    case (code)
      spf_pkg::EV_RDWR: if (cmdValid && cmdOk && !rEn) countInc = {23'h0, chunks};
      spf_pkg::EV_ACT: if (actIssue && !rEn && (!iEn || actRequesterId == rId)) countInc = 32'h0000_0001;
      spf_pkg::EV_RD: if (cmdValid && !cmdWrite && cmdOk) countInc = {23'h0, chunks};
      spf_pkg::EV_WR: if (cmdValid && cmdWrite && cmdOk) countInc = {23'h0, chunks};
      spf_pkg::EV_FULL: if (fifoFull && !rEn && !iEn) countInc = 32'h0000_0001;
      spf_pkg::EV_PRIO:
        if (prioRaise && regionOk(rEn, rSel, oldestRegion) && (!iEn || oldestRequesterId == rId))
          countInc = 32'h0000_0001;
      spf_pkg::EV_BUSY: if (fifoNotEmpty && !rEn && !iEn) countInc = 32'h0000_0001;
      default: countInc = 32'h0000_0000;
    endcase
  endfunction

  // Burst chunks, rounding a partial chunk up
  always_comb
  begin
    chunks = ({1'b0, cmdLen} + ((9'h001 << ctrl_reg[spf_pkg::BURST_LSB +: 3]) - 9'h001))
             >> ctrl_reg[spf_pkg::BURST_LSB +: 3];
  end

  // Per-counter increments from the config fields
  always_comb
  begin
    inc1 = countInc(config_reg[spf_pkg::CODE1_LSB +: 4], config_reg[spf_pkg::REGION_OFS],
                    config_reg[spf_pkg::REQ_OFS], select_reg[spf_pkg::RSEL1_LSB +: 4],
                    select_reg[spf_pkg::RID1_LSB +: 8]);
    inc2 = countInc(config_reg[spf_pkg::CODE2_LSB +: 4], config_reg[spf_pkg::REGION_OFS + 16],
                    config_reg[spf_pkg::REQ_OFS + 16], select_reg[spf_pkg::RSEL2_LSB +: 4],
                    select_reg[spf_pkg::RID2_LSB +: 8]);
  end

  assign apbAccess = psel && penable && pready;
  assign apbWrite = apbAccess && pwrite;

  // APB handshake, one wait state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        case (paddr)
          spf_pkg::ADDR_COUNT1: prdata <= count1_reg;
          spf_pkg::ADDR_COUNT2: prdata <= count2_reg;
          spf_pkg::ADDR_CONFIG: prdata <= config_reg;
          spf_pkg::ADDR_SELECT: prdata <= select_reg;
          spf_pkg::ADDR_CTRL: prdata <= ctrl_reg;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Selection registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_reg <= spf_pkg::CONFIG_RESET;
      select_reg <= 32'h0000_0000;
      ctrl_reg <= spf_pkg::CTRL_RESET;
    end
    else if (ce && apbWrite)
    begin
      if (paddr == spf_pkg::ADDR_CONFIG) config_reg <= pwdata & spf_pkg::CONFIG_MASK;
      if (paddr == spf_pkg::ADDR_SELECT) select_reg <= pwdata & spf_pkg::SELECT_MASK;
      if (paddr == spf_pkg::ADDR_CTRL) ctrl_reg <= pwdata & spf_pkg::CTRL_MASK;
    end
  end

  // Counters, a software write preloads
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count1_reg <= 32'h0000_0000;
      count2_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      count1_reg <= (apbWrite && paddr == spf_pkg::ADDR_COUNT1) ? pwdata : count1_reg + inc1;
      count2_reg <= (apbWrite && paddr == spf_pkg::ADDR_COUNT2) ? pwdata : count2_reg + inc2;
    end
  end

  // Threshold reached, nine bits so a saturated count cannot wrap
  always_comb
  begin
    thrHit = ({1'b0, xferCount_reg} + 9'h001) >= {1'b0, ctrl_reg[spf_pkg::THR_LSB +: 8]};
  end

  // Completed transfers since the last raise
  always_comb
  begin
    xferCount_next = xferCount_reg;
    if (xferDone && thrHit && fifoNotEmpty)
      xferCount_next = 8'h00;
    else if (xferDone && xferCount_reg != 8'hFF)
      xferCount_next = xferCount_reg + 8'h01;
  end

  // Starvation priority raise
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xferCount_reg <= 8'h00;
      prioRaise <= 1'b0;
    end
    else if (ce)
    begin
      xferCount_reg <= xferCount_next;
      prioRaise <= xferDone && fifoNotEmpty && thrHit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reserved_hold: assert property (ce && !apbWrite
    && config_reg[3:0] inside {4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF}
    |=> count1_reg == $past(count1_reg)) else $error("reserved code changed counter");
  a_act_one: assert property (ce && !apbWrite && config_reg[3:0] == 4'h1 && !config_reg[14] && !config_reg[15]
    && actIssue |=> count1_reg == $past(count1_reg) + 32'h1) else $error("activate not counted once");
  a_full_count: assert property (ce && !apbWrite && config_reg[19:16] == 4'h4 && config_reg[31:30] == 2'b00
    && fifoFull |=> count2_reg == $past(count2_reg) + 32'h1) else $error("full cycle not counted");
  a_busy_idle: assert property (ce && !apbWrite && config_reg[3:0] == 4'h9 && !fifoNotEmpty
    |=> count1_reg == $past(count1_reg)) else $error("empty fifo counted");
  a_read_skip: assert property (ce && !apbWrite && config_reg[3:0] == 4'h2 && !(cmdValid && !cmdWrite)
    |=> count1_reg == $past(count1_reg)) else $error("non-read counted");
  a_write_chunks: assert property (ce && !apbWrite && config_reg[3:0] == 4'h3 && config_reg[15:14] == 2'b00
    && cmdValid && cmdWrite |=> count1_reg == $past(count1_reg) + {23'h0, $past(chunks)})
    else $error("write not scaled");
  a_rdwr_region: assert property (ce && !apbWrite && config_reg[3:0] == 4'h0 && config_reg[14]
    |=> count1_reg == $past(count1_reg)) else $error("code 0 counted with region filter");
  a_req_filter: assert property (ce && !apbWrite && config_reg[3:0] == 4'h0 && config_reg[15]
    && cmdRequesterId != select_reg[15:8] |=> count1_reg == $past(count1_reg))
    else $error("foreign requester counted");
  a_region_regs: assert property (ce && !apbWrite && config_reg[3:0] == 4'h2 && config_reg[14]
    && select_reg[3:0] == 4'h7 && !cmdRegion |=> count1_reg == $past(count1_reg))
    else $error("sdram access counted under register region");
  a_prio_pulse: assert property (ce && xferDone && fifoNotEmpty && ctrl_reg[7:0] == 8'h03
    && xferCount_reg == 8'h02 |=> prioRaise) else $error("priority raise missing");
  a_apb_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no ready after access");

  c_starvation_threshold: cover property (prioRaise);
  c_read_count: cover property (ce && config_reg[3:0] == 4'h2 && cmdValid && !cmdWrite);
  c_full_count: cover property (ce && config_reg[19:16] == 4'h4 && fifoFull);
  c_apb_error: cover property (pready && pslverr);

endmodule

//--- spf_master_model.sv
module spf_master_model (
  input wire logic clk, // Controller clock
  input wire logic rst_b, // Async reset, active low
  input wire logic req, // Bench asks for one command
  input wire logic reqWrite, // Requested direction
  input wire logic reqRegion, // Requested target region
  input wire logic [7:0] reqId, // Requested master id
  input wire logic [7:0] reqLen, // Requested transfer bytes
  output logic cmdValid, // Command pulse
  output logic cmdWrite, // Command direction
  output logic cmdRegion, // Command region
  output logic [7:0] cmdRequesterId, // Command master id
  output logic [7:0] cmdLen // Command transfer bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  // One command per request; attributes scrambled between commands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmdValid <= 1'h0;
      {cmdWrite, cmdRegion, cmdRequesterId, cmdLen} <= 18'h0_0000;
    end
    else
    begin
      cmdValid <= req;
      if (req)
        {cmdWrite, cmdRegion, cmdRequesterId, cmdLen} <= {reqWrite, reqRegion, reqId, reqLen};
      else
        {cmdWrite, cmdRegion, cmdRequesterId, cmdLen} <= ~{cmdWrite, cmdRegion, cmdRequesterId, cmdLen};
    end
  end
endmodule

//--- spf_pkg.sv
// Function
// - Event code 0 counts every received read and write command, with the requester filter allowed and the region filter off.
// - Event codes 0, 2h and 3h add the transfer size split into chunks of the burst length programmed in control bits 10:8.
// - Event code 1h with the region filter off adds one for each ACTIVATE issued to a closed bank.
// - Event code 2h counts received read commands scaled by burst chunks, with both filters allowed.
// - Event code 3h counts received write commands scaled by burst chunks, with both filters allowed.
// - Event code 4h with both filters off adds one on every cycle that the command FIFO is full.
// - Event code 8h counts queued commands that needed a priority elevation, with both filters allowed.
// - The oldest queued command gets a priority raise once the starvation threshold of transfers has completed.
// - Event codes sit at bits 3:0 and 19:16, with the requester and region enables in bits 15:14 and 31:30.
// - With the region filter on, region select 0 keeps SDRAM accesses and 7h keeps controller register accesses.
// - With the requester filter on only accesses from the programmed 8-bit requester ID are counted.
package spf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_COUNT1 = 8'h00;
  localparam logic [7:0] ADDR_COUNT2 = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_SELECT = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  // Config fields
  localparam int CODE1_LSB = 0;
  localparam int CODE2_LSB = 16;
  localparam int REGION_OFS = 14;
  localparam int REQ_OFS = 15;
  localparam logic [31:0] CONFIG_MASK = 32'hC00F_C00F;
  localparam logic [31:0] CONFIG_RESET = 32'h0001_0000;
  // Select fields
  localparam int RSEL1_LSB = 0;
  localparam int RSEL2_LSB = 16;
  localparam int RID1_LSB = 8;
  localparam int RID2_LSB = 24;
  localparam logic [31:0] SELECT_MASK = 32'hFF0F_FF0F;
  // Control fields: threshold 7:0, burst length log2 10:8
  localparam int THR_LSB = 0;
  localparam int BURST_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0210;
  // Event codes
  localparam logic [3:0] EV_RDWR = 4'h0;
  localparam logic [3:0] EV_ACT = 4'h1;
  localparam logic [3:0] EV_RD = 4'h2;
  localparam logic [3:0] EV_WR = 4'h3;
  localparam logic [3:0] EV_FULL = 4'h4;
  localparam logic [3:0] EV_PRIO = 4'h8;
  localparam logic [3:0] EV_BUSY = 4'h9;
  // Region select values
  localparam logic [3:0] RSEL_SDRAM = 4'h0;
  localparam logic [3:0] RSEL_REGS = 4'h7;
endpackage

//--- tb_spf_event_filter.sv
module tb_spf_event_filter;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] cfg; logic [31:0] sel; logic w; logic rg; logic [7:0] id; logic [7:0] len;
    logic [31:0] exp;} spf_row_s;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, prioRaise, err;
  logic [7:0] paddr, cmdRequesterId, cmdLen, reqId, reqLen;
  logic [31:0] pwdata, prdata, data;
  logic cmdValid, cmdWrite, cmdRegion, req, reqWrite, reqRegion, actIssue, fifoFull, fifoNotEmpty, xferDone;
  int nFail = 0;
  int checkCount = 0;
  int cycles = 0;
  int seen;
  spf_row_s rows[11] = '{
    '{32'h0000_4000, 32'h0000_0000, 1'h0, 1'h0, 8'h03, 8'h10, 32'h0000_0000},
    '{32'h0000_0000, 32'h0000_0000, 1'h1, 1'h1, 8'h03, 8'h10, 32'h0000_0004},
    '{32'h0000_0002, 32'h0000_0000, 1'h0, 1'h0, 8'h03, 8'h08, 32'h0000_0002},
    '{32'h0000_0002, 32'h0000_0000, 1'h1, 1'h0, 8'h03, 8'h08, 32'h0000_0000},
    '{32'h0000_0003, 32'h0000_0000, 1'h1, 1'h0, 8'h03, 8'h0C, 32'h0000_0003},
    '{32'h0000_4003, 32'h0000_0007, 1'h1, 1'h1, 8'h03, 8'h04, 32'h0000_0001},
    '{32'h0000_4003, 32'h0000_0000, 1'h1, 1'h1, 8'h03, 8'h04, 32'h0000_0000},
    '{32'h0000_8002, 32'h0000_0500, 1'h0, 1'h0, 8'h05, 8'h04, 32'h0000_0001},
    '{32'h0000_8002, 32'h0000_0500, 1'h0, 1'h0, 8'h06, 8'h04, 32'h0000_0000},
    '{32'h0000_0005, 32'h0000_0000, 1'h1, 1'h0, 8'h03, 8'h10, 32'h0000_0000},
    '{32'h0000_000A, 32'h0000_0000, 1'h0, 1'h0, 8'h03, 8'h10, 32'h0000_0000}};
  spf_event_filter dut (.clk(clk), .rst_b(rst_b), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdRegion(cmdRegion), .cmdRequesterId(cmdRequesterId), .cmdLen(cmdLen),
    .actIssue(actIssue), .actRequesterId(8'h00), .fifoFull(fifoFull), .fifoNotEmpty(fifoNotEmpty),
    .xferDone(xferDone), .oldestRegion(1'h0), .oldestRequesterId(8'h00), .prioRaise(prioRaise));
  spf_master_model master (.clk(clk), .rst_b(rst_b), .req(req), .reqWrite(reqWrite), .reqRegion(reqRegion),
    .reqId(reqId), .reqLen(reqLen), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdRegion(cmdRegion),
    .cmdRequesterId(cmdRequesterId), .cmdLen(cmdLen));
  // Clock generation
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    data = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic w, input logic rg, input logic [7:0] id, input logic [7:0] len);
    @(posedge clk);
    {req, reqWrite, reqRegion, reqId, reqLen} <= {1'h1, w, rg, id, len};
    @(posedge clk);
    req <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nFail++;
      give_verdict();
    end
  end
  // Main sequence
  initial
  begin
    {rst_b, psel, penable, pwrite, req, reqWrite, reqRegion, actIssue, fifoFull, fifoNotEmpty, xferDone} = 11'h000;
    {paddr, reqId, reqLen, pwdata} = 56'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    apb(1'h0, spf_pkg::ADDR_CONFIG, 32'h0000_0000);
    chk(data, spf_pkg::CONFIG_RESET);
    apb(1'h0, spf_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(data, spf_pkg::CTRL_RESET);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("Test reset done");
    foreach (rows[i])
    begin
      apb(1'h1, spf_pkg::ADDR_CONFIG, rows[i].cfg);
      apb(1'h1, spf_pkg::ADDR_SELECT, rows[i].sel);
      apb(1'h1, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
      send(rows[i].w, rows[i].rg, rows[i].id, rows[i].len);
      apb(1'h0, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
      chk(data, rows[i].exp);
      $display("Test row %0d done", i);
    end
    // Back-to-back ACTIVATE pulses on counter two
    apb(1'h1, spf_pkg::ADDR_CONFIG, 32'h0001_0000);
    apb(1'h1, spf_pkg::ADDR_COUNT2, 32'h0000_0000);
    actIssue <= 1'h1;
    repeat (2) @(posedge clk);
    actIssue <= 1'h0;
    apb(1'h0, spf_pkg::ADDR_COUNT2, 32'h0000_0000);
    chk(data, 32'h0000_0002);
    $display("Test activate done");
    // FIFO full for 3 cycles inside 5 busy cycles
    apb(1'h1, spf_pkg::ADDR_CONFIG, 32'h0009_0004);
    apb(1'h1, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
    apb(1'h1, spf_pkg::ADDR_COUNT2, 32'h0000_0000);
    {fifoFull, fifoNotEmpty} <= 2'h3;
    repeat (3) @(posedge clk);
    fifoFull <= 1'h0;
    repeat (2) @(posedge clk);
    fifoNotEmpty <= 1'h0;
    apb(1'h0, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
    chk(data, 32'h0000_0003);
    apb(1'h0, spf_pkg::ADDR_COUNT2, 32'h0000_0000);
    chk(data, 32'h0000_0005);
    $display("Test fifo done");
    // Threshold 3: third completed transfer raises priority once
    apb(1'h1, spf_pkg::ADDR_CTRL, 32'h0000_0203);
    apb(1'h1, spf_pkg::ADDR_CONFIG, 32'h0000_0008);
    apb(1'h1, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
    {fifoNotEmpty, xferDone} <= 2'h3;
    repeat (3) @(posedge clk);
    xferDone <= 1'h0;
    seen = 0;
    repeat (4) @(posedge clk) if (prioRaise === 1'h1) seen++;
    fifoNotEmpty <= 1'h0;
    chk(seen, 32'h0000_0001);
    apb(1'h0, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
    chk(data, 32'h0000_0001);
    $display("Test starvation done");
    // Mid-run reset restores the config register and clears counter one
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    apb(1'h0, spf_pkg::ADDR_CONFIG, 32'h0000_0000);
    chk(data, spf_pkg::CONFIG_RESET);
    apb(1'h0, spf_pkg::ADDR_COUNT1, 32'h0000_0000);
    chk(data, 32'h0000_0000);
    $display("Test mid reset done");
    give_verdict();
  end
endmodule
